// >>> include/iflv_pkg.sv
// Package for the input fault live status bank: register offsets, field positions,
// reset values and the packed structs that carry detector levels.
// Assumes an 8-bit control port with 8-bit register addresses.
`default_nettype none
package iflv_pkg;
  localparam logic [7:0] CH1_INPUT_FAULT_LIVE_ADDR    = 8'h3e;
  localparam logic [7:0] CH2_INPUT_FAULT_LIVE_ADDR    = 8'h3f;
  localparam logic [7:0] OVERVOLTAGE_LIVE_FLAGS_ADDR  = 8'h42;
  localparam logic [7:0] BIAS_MONITOR_LIVE_FLAGS_ADDR = 8'h43;
  localparam logic [7:0] LIVE_RESET                   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ                = 8'h00;
  localparam logic [3:0] OVERVOLTAGE_RESERVED_VALUE   = 4'h0;
  localparam int         CH1_SCAN_ENABLE_BIT          = 7;
  localparam int         CH2_SCAN_ENABLE_BIT          = 6;
  localparam int         SYNC_STAGES                  = 2;

  // Field positions inside each channel register.
  localparam int         CH_OPEN_PAIR_BIT             = 7;
  localparam int         CH_PAIR_SHORTED_BIT          = 6;
  localparam int         CH_POS_GROUND_BIT            = 5;
  localparam int         CH_NEG_GROUND_BIT            = 4;
  localparam int         CH_POS_BIAS_BIT              = 3;
  localparam int         CH_NEG_BIAS_BIT              = 2;
  localparam int         CH_POS_BATTERY_BIT           = 1;
  localparam int         CH_NEG_BATTERY_BIT           = 0;

  // Field positions inside the over-voltage register.
  localparam int         OV_CH1_POS_BIT               = 7;
  localparam int         OV_CH1_NEG_BIT               = 6;
  localparam int         OV_CH2_POS_BIT               = 5;
  localparam int         OV_CH2_NEG_BIT               = 4;
  localparam int         OV_RESERVED_MSB              = 3;
  localparam int         OV_RESERVED_LSB              = 0;

  // Field positions inside the bias-monitor register.
  localparam int         BM_UPPER_BIT                 = 7;
  localparam int         BM_LOWER_BIT                 = 6;
  localparam int         BM_VOICE_UP_BIT              = 5;
  localparam int         BM_VOICE_DOWN_BIT            = 4;
  localparam int         BM_SHORT_BIT                 = 3;
  localparam int         BM_HIGH_CURRENT_BIT          = 2;
  localparam int         BM_LOW_CURRENT_BIT           = 1;
  localparam int         BM_OVERVOLTAGE_BIT           = 0;

  // Per-channel input fault levels; field order gives the register bit order 7 to 0.
  typedef struct packed {
    logic open_pair;
    logic pair_shorted;
    logic pos_to_ground;
    logic neg_to_ground;
    logic pos_to_bias;
    logic neg_to_bias;
    logic pos_to_battery;
    logic neg_to_battery;
  } iflv_channel_fault_type;

  typedef struct packed {
    logic ch1_pos_overvoltage;
    logic ch1_neg_overvoltage;
    logic ch2_pos_overvoltage;
    logic ch2_neg_overvoltage;
  } iflv_overvoltage_type;

  typedef struct packed {
    logic monitor_upper;
    logic monitor_lower;
    logic voice_power_up;
    logic voice_power_down;
    logic bias_short;
    logic bias_high_current;
    logic bias_low_current;
    logic bias_overvoltage;
  } iflv_bias_monitor_type;

  typedef struct packed {
    iflv_channel_fault_type ch1;
    iflv_channel_fault_type ch2;
    iflv_overvoltage_type   overvoltage;
    iflv_bias_monitor_type  bias_monitor;
  } iflv_detector_type;
endpackage
`default_nettype wire

// >>> logic/iflv_live_status.sv
// Read-only bank of live input fault and interrupt cause flags.
// Assumes detector levels arrive asynchronously from analogue circuits and that the control
// port presents a register address with a read strobe on sys_clk.
//
// Contract
// R1: Channel-one register bit 7 shows open input pair.
// R2: Channel-one bit 6 shows inputs shorted to each other.
// R3: Channel-one bits 5 and 4 show positive and negative shorted to ground.
// R4: Channel-one bits 3 and 2 show pins shorted to bias supply.
// R5: Channel-one bits 1 and 0 show pins shorted to battery sense.
// R6: Channel-two register bit 7 shows open input pair.
// R7: Channel-two bit 6 shows inputs shorted to each other.
// R8: Channel-two bits 5 and 4 show pins shorted to ground.
// R9: Channel-two bits 3 and 2 show pins shorted to bias supply.
// R10: Channel-two bits 1 and 0 show pins shorted to battery sense.
// R11: Over-voltage register bits 7 and 6 flag channel-one pin over-voltage.
// R12: Over-voltage register bits 5 and 4 flag channel-two pin over-voltage.
// R13: Over-voltage bits 3 to 0 reserved, read zero; software writes zero.
// R14: Bias-monitor bits 7 and 6 show monitor upper and lower threshold faults.
// R15: Bias-monitor bits 5 and 4 show voice-activity power-up and power-down.
// R16: Bias-monitor bit 3 shows bias-supply short circuit.
// R17: Bias-monitor bits 2 and 1 show bias high and low current.
// R18: Bias-monitor bit 0 shows bias-supply over-voltage.
// R19: Interrupt flags here are live, not latched, and read-only.
// R20: Channel registers hold live fault status, read-only, zero after reset.
// R21: Latched counterparts clear on read; these live flags do not.
// R22: Channel diagnostics report only while that channel's scan enable is set.
// R23: Flags resample every cycle; reads have no side effect; writes ignored.
// R24: Analogue detector levels pass a two-stage synchroniser first.
`default_nettype none
module iflv_live_status (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire iflv_pkg::iflv_detector_type detector_level,
  input  wire logic                        ch1_scan_enable,
  input  wire logic                        ch2_scan_enable,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_read,
  input  wire logic                        reg_write,
  input  wire logic [7:0]                  reg_wdata,
  output logic [7:0]                       reg_rdata,
  output logic                             reg_hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser and live flag state.

  iflv_pkg::iflv_detector_type sync_first;
  iflv_pkg::iflv_detector_type sync_second;
  iflv_pkg::iflv_detector_type live;
  iflv_pkg::iflv_detector_type next_live;
  logic [7:0]                  ch1_image;
  logic [7:0]                  ch2_image;
  logic [7:0]                  overvoltage_image;
  logic [7:0]                  bias_monitor_image;
  logic [3:0]                  read_select;
  logic [7:0]                  next_reg_rdata;
  logic                        next_reg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding. One one-hot select serves both the hit flag and the
  // data mux, so the two can never disagree about which addresses exist.

  function automatic logic [3:0] decode_select(input logic [7:0] addr);
    decode_select    = 4'h0;
    decode_select[0] = (addr == iflv_pkg::CH1_INPUT_FAULT_LIVE_ADDR);
    decode_select[1] = (addr == iflv_pkg::CH2_INPUT_FAULT_LIVE_ADDR);
    decode_select[2] = (addr == iflv_pkg::OVERVOLTAGE_LIVE_FLAGS_ADDR);
    decode_select[3] = (addr == iflv_pkg::BIAS_MONITOR_LIVE_FLAGS_ADDR);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = |decode_select(addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register images. Fields are placed by position constants, so moving a
  // field touches the package only and never the struct order.

  function automatic logic [7:0] channel_image(input iflv_pkg::iflv_channel_fault_type f);
    channel_image                                = iflv_pkg::LIVE_RESET;
    channel_image[iflv_pkg::CH_OPEN_PAIR_BIT]    = f.open_pair;      // see R1 see R6
    channel_image[iflv_pkg::CH_PAIR_SHORTED_BIT] = f.pair_shorted;   // see R2 see R7
    channel_image[iflv_pkg::CH_POS_GROUND_BIT]   = f.pos_to_ground;  // see R3 see R8
    channel_image[iflv_pkg::CH_NEG_GROUND_BIT]   = f.neg_to_ground;  // see R3 see R8
    channel_image[iflv_pkg::CH_POS_BIAS_BIT]     = f.pos_to_bias;    // see R4 see R9
    channel_image[iflv_pkg::CH_NEG_BIAS_BIT]     = f.neg_to_bias;    // see R4 see R9
    channel_image[iflv_pkg::CH_POS_BATTERY_BIT]  = f.pos_to_battery; // see R5 see R10
    channel_image[iflv_pkg::CH_NEG_BATTERY_BIT]  = f.neg_to_battery; // see R5 see R10
  endfunction

  // The reserved low nibble is driven from its constant, never from a detector,
  // so a stray level on an unused line cannot leak into a read.
  function automatic logic [7:0] overvoltage_fields(input iflv_pkg::iflv_overvoltage_type f);
    overvoltage_fields                           = iflv_pkg::LIVE_RESET;
    overvoltage_fields[iflv_pkg::OV_CH1_POS_BIT] = f.ch1_pos_overvoltage; // see R11
    overvoltage_fields[iflv_pkg::OV_CH1_NEG_BIT] = f.ch1_neg_overvoltage; // see R11
    overvoltage_fields[iflv_pkg::OV_CH2_POS_BIT] = f.ch2_pos_overvoltage; // see R12
    overvoltage_fields[iflv_pkg::OV_CH2_NEG_BIT] = f.ch2_neg_overvoltage; // see R12
    overvoltage_fields[iflv_pkg::OV_RESERVED_MSB:iflv_pkg::OV_RESERVED_LSB] =
      iflv_pkg::OVERVOLTAGE_RESERVED_VALUE;                               // see R13
  endfunction

  function automatic logic [7:0] bias_fields(input iflv_pkg::iflv_bias_monitor_type f);
    bias_fields                                = iflv_pkg::LIVE_RESET;
    bias_fields[iflv_pkg::BM_UPPER_BIT]        = f.monitor_upper;     // see R14
    bias_fields[iflv_pkg::BM_LOWER_BIT]        = f.monitor_lower;     // see R14
    bias_fields[iflv_pkg::BM_VOICE_UP_BIT]     = f.voice_power_up;    // see R15
    bias_fields[iflv_pkg::BM_VOICE_DOWN_BIT]   = f.voice_power_down;  // see R15
    bias_fields[iflv_pkg::BM_SHORT_BIT]        = f.bias_short;        // see R16
    bias_fields[iflv_pkg::BM_HIGH_CURRENT_BIT] = f.bias_high_current; // see R17
    bias_fields[iflv_pkg::BM_LOW_CURRENT_BIT]  = f.bias_low_current;  // see R17
    bias_fields[iflv_pkg::BM_OVERVOLTAGE_BIT]  = f.bias_overvoltage;  // see R18
  endfunction

  // The first stage feeds only the second stage; nothing else looks at it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_first  <= '0;
      sync_second <= '0;
    end else begin
      sync_first  <= detector_level;                       // see R24
      sync_second <= sync_first;                           // see R24
    end
  end

  // Scan enables come from logic on this clock, so they gate without synchronising.
  // A disabled channel's register reports no faults rather than a stale scan result; its over-voltage flags still show.
  always_comb begin
    next_live     = sync_second;                           // see R19 see R23
    next_live.ch1 = ch1_scan_enable ? sync_second.ch1 : '0; // see R22
    next_live.ch2 = ch2_scan_enable ? sync_second.ch2 : '0; // see R22
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      live <= '0;                                          // see R20
    end else begin
      live <= next_live;                                   // see R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port. Reads change no state, unlike the latched copies kept elsewhere,
  // and writes are dropped, so reg_write and reg_wdata steer nothing here.

  // Images are built from the registered live flags, never from the synchroniser,
  // so a read always returns one coherent sample of every field.
  always_comb begin
    ch1_image          = channel_image(live.ch1);          // see R1 see R2 see R3 see R4 see R5
    ch2_image          = channel_image(live.ch2);          // see R6 see R7 see R8 see R9 see R10
    overvoltage_image  = overvoltage_fields(live.overvoltage); // see R11 see R12 see R13
    bias_monitor_image = bias_fields(live.bias_monitor);   // see R14 see R16 see R18
  end

  // Without a read the data register keeps its last value, so software that
  // samples late still sees the byte it asked for.
  always_comb begin
    read_select    = decode_select(reg_addr);
    next_reg_hit   = reg_read && mapped(reg_addr);
    next_reg_rdata = reg_rdata;
    if (reg_read) begin                                    // see R21 see R23
      unique case (read_select)
        4'h1: begin
          next_reg_rdata = ch1_image;                      // see R20
        end
        4'h2: begin
          next_reg_rdata = ch2_image;                      // see R20
        end
        4'h4: begin
          next_reg_rdata = overvoltage_image;              // see R19
        end
        4'h8: begin
          next_reg_rdata = bias_monitor_image;             // see R19
        end
        default: begin
          next_reg_rdata = iflv_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= iflv_pkg::LIVE_RESET;
      reg_hit   <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_hit   <= next_reg_hit;
    end
  end

endmodule
`default_nettype wire

// >>> tb/iflv_live_status_chk.sv
// Checker for the live status bank, bound to the bank's ports.
// Assumes detector levels stay steady for five cycles before each mapped read.
`default_nettype none
module iflv_live_status_chk (
  input wire logic                        sys_clk,
  input wire logic                        rst,
  input wire iflv_pkg::iflv_detector_type detector_level,
  input wire logic                        ch1_scan_enable,
  input wire logic                        ch2_scan_enable,
  input wire logic [7:0]                  reg_addr,
  input wire logic                        reg_read,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        reg_hit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Five steady samples cover the synchroniser and the live stage.
  sequence s_calm;
    ($stable(detector_level) && $stable({ch1_scan_enable, ch2_scan_enable}))[*5];
  endsequence
  sequence s_rd(logic [7:0] a);
    s_calm ##0 (reg_read && reg_addr == a);
  endsequence
  a_ch1_read_map: assert property (s_rd(8'h3e) |=> reg_hit &&
    reg_rdata == ($past(ch1_scan_enable) ? $past(detector_level.ch1) : 8'h00)) else $error("ch1");
  a_ch2_read_map: assert property (s_rd(8'h3f) |=> reg_hit &&
    reg_rdata == ($past(ch2_scan_enable) ? $past(detector_level.ch2) : 8'h00)) else $error("ch2");
  a_ovr_read_map: assert property (s_rd(8'h42) |=> reg_hit &&
    reg_rdata == {$past(detector_level.overvoltage), 4'h0}) else $error("overvoltage");
  a_bias_read_map: assert property (s_rd(8'h43) |=> reg_hit &&
    reg_rdata == $past(detector_level.bias_monitor)) else $error("bias monitor");
  a_unmapped_zero: assert property (reg_read &&
    !(reg_addr inside {8'h3e, 8'h3f, 8'h42, 8'h43}) |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped");
  a_hit_needs_read: assert property (!reg_read |=> !reg_hit) else $error("hit");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("hold");
  a_reset_clear: assert property ($past(rst) |-> reg_rdata == 8'h00 && !reg_hit)
    else $error("reset");
endmodule
bind iflv_live_status iflv_live_status_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .detector_level(detector_level), .ch1_scan_enable(ch1_scan_enable),
  .ch2_scan_enable(ch2_scan_enable), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit));
`default_nettype wire

// >>> tb/iflv_live_status_tb.sv
// Self-checking bench for the live status bank.
// Assumes read data and hit appear just after the edge that takes the read.
`default_nettype none
module iflv_live_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        sys_clk = 0, rst = 1, en1 = 0, en2 = 0, rd = 0, wr = 0, hit;
  logic [7:0]                  addr = 8'h00, wdata = 8'h00, rdata;
  iflv_pkg::iflv_detector_type det = '0;
  logic [8:0]                  q[$];
  logic [7:0]                  burst [5] = '{8'h3e, 8'h3f, 8'h42, 8'h43, 8'h42};
  int                          seed = 97, n_fail = 0, checked = 0, cyc = 0;
  iflv_live_status u_dut (.sys_clk(sys_clk), .rst(rst), .detector_level(det),
    .ch1_scan_enable(en1), .ch2_scan_enable(en2), .reg_addr(addr), .reg_read(rd),
    .reg_write(wr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit));
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [8:0] ex(input logic [7:0] a);
    case (a)
      8'h3e: return {1'b1, en1 ? det.ch1 : 8'h00};
      8'h3f: return {1'b1, en2 ? det.ch2 : 8'h00};
      8'h42: return {1'b1, det.overvoltage, 4'h0};
      8'h43: return {1'b1, det.bias_monitor};
      default: return 9'h000;
    endcase
  endfunction
  // Every cycle also drives random wr and wdata, so about half carry a write, which must never disturb a read.
  task automatic rdx(input logic [7:0] a, input logic [8:0] e);
    @(posedge sys_clk);
    #1;
    addr = a;
    rd = 1'b1;
    {wr, wdata} = 9'($random(seed));
    q.push_back(e);
  endtask
  task automatic chk(input logic [8:0] e);
    checked++;
    if ({hit, rdata} !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, {hit, rdata}, e);
    end
  endtask
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rd && !rst) begin
      #2;
      chk(q.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 40; i++) begin
      // The stale read proves a fresh level has not yet crossed the synchroniser.
      rdx(8'h43, ex(8'h43));
      det = 28'($random(seed));
      {en1, en2} = 2'($random(seed));
      repeat (5) begin
        @(posedge sys_clk);
        #1 rd = 1'b0;
        {wr, wdata, addr} = 17'($random(seed));
      end
      foreach (burst[k]) rdx(burst[k], ex(burst[k]));
      rdx(8'($random(seed)), 9'h000);
      q[$] = ex(addr);
      $display("test %0d done", i);
    end
    @(posedge sys_clk);
    #1 rd = 1'b0;
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule
`default_nettype wire
